/* File: crsig_pkg.sv */
package crsig_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PRIO_W = 8;
    localparam int BP_W = 3;
    localparam int EV_W = 3;
    localparam int LINE_W = 4;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] BPR_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] ABPR_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] MASK_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] LINE_OFS = 8'h14;

    // cpu_if_control field positions
    localparam int G0_EN_BIT = 0;
    localparam int G1_EN_BIT = 1;
    localparam int FAST_ROUTE_BIT = 3;
    localparam int CBP_SEL_BIT = 4;
    localparam int FIQ_BYP_OFF_BIT = 5;
    localparam int IRQ_BYP_OFF_BIT = 6;
    localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h0000007B;

    // event and line-state bit positions
    localparam int EV_IRQ_BIT = 0;
    localparam int EV_FIQ_BIT = 1;
    localparam int EV_BYP_BIT = 2;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h00000000;
    localparam logic [BP_W-1:0] BPR_RST = 3'h0;
    localparam logic [BP_W-1:0] ABPR_RST = 3'h0;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CRSIG_WS_IDLE = 2'h0,
        CRSIG_WS_RESP = 2'h1,
        CRSIG_WS_GOT_A = 2'h3,
        CRSIG_WS_GOT_D = 2'h2
    } crsig_wstate_t;

    typedef enum logic {
        CRSIG_RS_IDLE = 1'h0,
        CRSIG_RS_DATA = 1'h1
    } crsig_rstate_t;
endpackage : crsig_pkg

/* File: crsig_cmp_if.sv */
`timescale 1ns/1ns
interface crsig_cmp_if;
    import crsig_pkg::*;
    logic [BP_W-1:0] bp;
    logic [PRIO_W-1:0] cand;
    logic [PRIO_W-1:0] running;
    logic preempt;
    modport ctl (output bp, output cand, output running, input preempt);
    modport cmp (input bp, input cand, input running, output preempt);
endinterface : crsig_cmp_if

/* File: crsig_sync.sv */
`timescale 1ns/1ns
module crsig_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // async in, synced out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // first stage feeds only the second
    always_comb begin
        meta_next = ce ? d : meta_reg;
        q_next = ce ? meta_reg : q_reg;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule : crsig_sync

/* File: crsig_grp_cmp.sv */
`timescale 1ns/1ns
module crsig_grp_cmp (
    // compare channel
    crsig_cmp_if.cmp p
);
    import crsig_pkg::*;
    logic [3:0] shamt;
    logic [PRIO_W-1:0] grp_mask;

    // bits below the binary point are subpriority and never preempt
    always_comb begin
        shamt = {1'b0, p.bp} + 4'h1;
        grp_mask = 8'hFF << shamt;
        p.preempt = (p.cand & grp_mask) < (p.running & grp_mask);
    end
endmodule : crsig_grp_cmp

/* File: crsig_ctrl.sv */
// Functional notes
// - normal line off: bypass normal signal passes when bit 6 is 0, blocked when 1.
// - fast line off: bypass fast signal passes when bit 5 is 0, blocked when 1.
// - bit 4 chooses whether main binary point governs both groups.
// - separate control: group 0 uses main, group 1 uses aliased binary point.
// - common control: both groups judged with main binary point only.
// - bit 3 routes group 0 to normal line at 0, fast line at 1.
// - group 1 always uses the normal line, never the fast line.
// - bit 3 resets to 0; all-normal-line software keeps it 0.
// - bit 0 enables group 0 signaling when 1, disables when 0.
// - bit 1 enables group 1 signaling when 1, disables when 0.
`timescale 1ns/1ns
module crsig_ctrl (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // axi4-lite write address and data
    input wire logic [crsig_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [crsig_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [crsig_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [crsig_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pending interrupts from the distributor
    input wire logic g0_pending,
    input wire logic g1_pending,
    input wire logic [crsig_pkg::PRIO_W-1:0] g0_cand_prio,
    input wire logic [crsig_pkg::PRIO_W-1:0] g1_cand_prio,
    input wire logic [crsig_pkg::PRIO_W-1:0] running_prio,
    // bypass pins
    input wire logic bypass_irq_pin,
    input wire logic bypass_fiq_pin,
    // processor side
    output logic normal_interrupt_line,
    output logic fast_interrupt_line,
    output logic g0_preempt,
    output logic g1_preempt,
    // system interrupt
    output logic sys_intr
);
    import crsig_pkg::*;

    crsig_wstate_t wstate_reg;
    crsig_wstate_t wstate_next;
    crsig_rstate_t rstate_reg;
    crsig_rstate_t rstate_next;
    logic [ADDR_W-1:0] waddr_reg;
    logic [ADDR_W-1:0] waddr_next;
    logic [DATA_W-1:0] wdat_reg;
    logic [DATA_W-1:0] wdat_next;
    logic [3:0] wstb_reg;
    logic [3:0] wstb_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] ctrl_next;
    logic [BP_W-1:0] bpr_reg;
    logic [BP_W-1:0] bpr_next;
    logic [BP_W-1:0] abpr_reg;
    logic [BP_W-1:0] abpr_next;
    logic [EV_W-1:0] stat_reg;
    logic [EV_W-1:0] stat_next;
    logic [EV_W-1:0] mask_reg;
    logic [EV_W-1:0] mask_next;
    logic [EV_W-1:0] prev_reg;
    logic [EV_W-1:0] prev_next;
    logic irq_reg;
    logic irq_next;
    logic fiq_reg;
    logic fiq_next;
    logic g0p_reg;
    logic g0p_next;
    logic g1p_reg;
    logic g1p_next;
    logic [1:0] byp_sync;
    logic byp_irq;
    logic byp_fiq;
    logic wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic g0_sig;
    logic g1_sig;
    logic irq_off;
    logic fiq_off;
    logic irq_path;
    logic fiq_path;
    logic byp_used;
    logic [EV_W-1:0] ev_now;
    logic [EV_W-1:0] ev_rise;

    crsig_cmp_if g0_cmp ();
    crsig_cmp_if g1_cmp ();

    // bypass pins come from outside the clock domain
    crsig_sync #(.W(2)) u_byp_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d({bypass_fiq_pin, bypass_irq_pin}),
        .q(byp_sync)
    );
    assign byp_irq = byp_sync[0];
    assign byp_fiq = byp_sync[1];

    crsig_grp_cmp u_g0_cmp (.p(g0_cmp.cmp));
    crsig_grp_cmp u_g1_cmp (.p(g1_cmp.cmp));

    // binary point selection per group
    always_comb begin
        g0_cmp.bp = bpr_reg;
        g1_cmp.bp = ctrl_reg[CBP_SEL_BIT] ? bpr_reg : abpr_reg;
        g0_cmp.cand = g0_cand_prio;
        g1_cmp.cand = g1_cand_prio;
        g0_cmp.running = running_prio;
        g1_cmp.running = running_prio;
    end

    // signal routing to the processor
    always_comb begin
        g0_sig = ctrl_reg[G0_EN_BIT] & g0_pending;
        g1_sig = ctrl_reg[G1_EN_BIT] & g1_pending;
        irq_path = (g0_sig & ~ctrl_reg[FAST_ROUTE_BIT]) | g1_sig;
        fiq_path = g0_sig & ctrl_reg[FAST_ROUTE_BIT];
        // a line counts as disabled when no enabled group is routed to it
        irq_off = ~ctrl_reg[G1_EN_BIT] & ~(ctrl_reg[G0_EN_BIT] & ~ctrl_reg[FAST_ROUTE_BIT]);
        fiq_off = ~(ctrl_reg[G0_EN_BIT] & ctrl_reg[FAST_ROUTE_BIT]);
        irq_next = irq_off ? (byp_irq & ~ctrl_reg[IRQ_BYP_OFF_BIT]) : irq_path;
        fiq_next = fiq_off ? (byp_fiq & ~ctrl_reg[FIQ_BYP_OFF_BIT]) : fiq_path;
        byp_used = (irq_off & byp_irq & ~ctrl_reg[IRQ_BYP_OFF_BIT])
            | (fiq_off & byp_fiq & ~ctrl_reg[FIQ_BYP_OFF_BIT]);
        g0p_next = g0_sig & g0_cmp.preempt;
        g1p_next = g1_sig & g1_cmp.preempt;
        if (!ce) begin
            irq_next = irq_reg;
            fiq_next = fiq_reg;
            g0p_next = g0p_reg;
            g1p_next = g1p_reg;
        end
    end

    // axi4-lite write channel: address and data in either order
    always_comb begin
        wstate_next = wstate_reg;
        waddr_next = waddr_reg;
        wdat_next = wdat_reg;
        wstb_next = wstb_reg;
        bresp_next = bresp_reg;
        awready = (wstate_reg == CRSIG_WS_IDLE) | (wstate_reg == CRSIG_WS_GOT_D);
        wready = (wstate_reg == CRSIG_WS_IDLE) | (wstate_reg == CRSIG_WS_GOT_A);
        wr_addr = (wstate_reg == CRSIG_WS_GOT_A) ? waddr_reg : awaddr;
        wr_data = (wstate_reg == CRSIG_WS_GOT_D) ? wdat_reg : wdata;
        wr_strb = (wstate_reg == CRSIG_WS_GOT_D) ? wstb_reg : wstrb;
        wr_fire = 1'b0;
        if (ce) begin
            case (wstate_reg)
                CRSIG_WS_IDLE: begin
                    if (awvalid && wvalid) begin
                        wr_fire = 1'b1;
                    end else if (awvalid) begin
                        waddr_next = awaddr;
                        wstate_next = CRSIG_WS_GOT_A;
                    end else if (wvalid) begin
                        wdat_next = wdata;
                        wstb_next = wstrb;
                        wstate_next = CRSIG_WS_GOT_D;
                    end
                end
                CRSIG_WS_GOT_A: begin
                    wr_fire = wvalid;
                end
                CRSIG_WS_GOT_D: begin
                    wr_fire = awvalid;
                end
                CRSIG_WS_RESP: begin
                    if (bready) begin
                        wstate_next = CRSIG_WS_IDLE;
                    end
                end
                default: begin
                    wstate_next = CRSIG_WS_IDLE;
                end
            endcase
        end else begin
            awready = 1'b0;
            wready = 1'b0;
        end
        if (wr_fire) begin
            wstate_next = CRSIG_WS_RESP;
            bresp_next = RESP_OKAY;
            if (wr_addr != CTRL_OFS && wr_addr != BPR_OFS && wr_addr != ABPR_OFS
                && wr_addr != STAT_OFS && wr_addr != MASK_OFS && wr_addr != LINE_OFS) begin
                bresp_next = RESP_SLVERR;
            end
        end
    end
    assign bvalid = (wstate_reg == CRSIG_WS_RESP);
    assign bresp = bresp_reg;

    // register file, events and status
    always_comb begin
        ctrl_next = ctrl_reg;
        bpr_next = bpr_reg;
        abpr_next = abpr_reg;
        mask_next = mask_reg;
        ev_now = '0;
        ev_now[EV_IRQ_BIT] = irq_reg;
        ev_now[EV_FIQ_BIT] = fiq_reg;
        ev_now[EV_BYP_BIT] = byp_used;
        ev_rise = ev_now & ~prev_reg;
        prev_next = ce ? ev_now : prev_reg;
        stat_next = stat_reg;
        // all fields sit in the low byte, so only lane 0 matters
        if (wr_fire && wr_strb[0]) begin
            if (wr_addr == CTRL_OFS) begin
                ctrl_next = wr_data & CTRL_WMASK;
            end else if (wr_addr == BPR_OFS) begin
                bpr_next = wr_data[BP_W-1:0];
            end else if (wr_addr == ABPR_OFS) begin
                abpr_next = wr_data[BP_W-1:0];
            end else if (wr_addr == STAT_OFS) begin
                stat_next = stat_reg & ~wr_data[EV_W-1:0];
            end else if (wr_addr == MASK_OFS) begin
                mask_next = wr_data[EV_W-1:0];
            end
        end
        // a new event beats a same-cycle clear
        if (ce) begin
            stat_next = stat_next | ev_rise;
        end
    end
    assign sys_intr = |(stat_reg & mask_reg);

    // axi4-lite read channel
    always_comb begin
        rstate_next = rstate_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        arready = ce & (rstate_reg == CRSIG_RS_IDLE);
        if (ce) begin
            case (rstate_reg)
                CRSIG_RS_IDLE: begin
                    if (arvalid) begin
                        rstate_next = CRSIG_RS_DATA;
                        rresp_next = RESP_OKAY;
                        rdata_next = '0;
                        if (araddr == CTRL_OFS) begin
                            rdata_next = ctrl_reg;
                        end else if (araddr == BPR_OFS) begin
                            rdata_next[BP_W-1:0] = bpr_reg;
                        end else if (araddr == ABPR_OFS) begin
                            rdata_next[BP_W-1:0] = abpr_reg;
                        end else if (araddr == STAT_OFS) begin
                            rdata_next[EV_W-1:0] = stat_reg;
                        end else if (araddr == MASK_OFS) begin
                            rdata_next[EV_W-1:0] = mask_reg;
                        end else if (araddr == LINE_OFS) begin
                            rdata_next[LINE_W-1:0] = {byp_fiq, byp_irq, fiq_reg, irq_reg};
                        end else begin
                            rresp_next = RESP_SLVERR;
                        end
                    end
                end
                CRSIG_RS_DATA: begin
                    if (rready) begin
                        rstate_next = CRSIG_RS_IDLE;
                    end
                end
                default: begin
                    rstate_next = CRSIG_RS_IDLE;
                end
            endcase
        end
    end
    assign rvalid = (rstate_reg == CRSIG_RS_DATA);
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wstate_reg <= CRSIG_WS_IDLE;
            rstate_reg <= CRSIG_RS_IDLE;
            waddr_reg <= '0;
            wdat_reg <= '0;
            wstb_reg <= 4'h0;
            bresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            ctrl_reg <= CTRL_RST;
            bpr_reg <= BPR_RST;
            abpr_reg <= ABPR_RST;
            stat_reg <= EV_RST;
            mask_reg <= EV_RST;
            prev_reg <= EV_RST;
            irq_reg <= 1'b0;
            fiq_reg <= 1'b0;
            g0p_reg <= 1'b0;
            g1p_reg <= 1'b0;
        end else begin
            wstate_reg <= wstate_next;
            rstate_reg <= rstate_next;
            waddr_reg <= waddr_next;
            wdat_reg <= wdat_next;
            wstb_reg <= wstb_next;
            bresp_reg <= bresp_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            ctrl_reg <= ctrl_next;
            bpr_reg <= bpr_next;
            abpr_reg <= abpr_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            prev_reg <= prev_next;
            irq_reg <= irq_next;
            fiq_reg <= fiq_next;
            g0p_reg <= g0p_next;
            g1p_reg <= g1p_next;
        end
    end

    assign normal_interrupt_line = irq_reg;
    assign fast_interrupt_line = fiq_reg;
    assign g0_preempt = g0p_reg;
    assign g1_preempt = g1p_reg;
endmodule : crsig_ctrl

/* File: crsig_core_model.sv */
`timescale 1ns/1ns
module crsig_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // lines from the interface
    input wire logic normal_interrupt_line,
    input wire logic fast_interrupt_line,
    // taken interrupts
    output logic [7:0] irq_cnt,
    output logic [7:0] fiq_cnt
);
    logic [1:0] last_reg;
    // the core takes an interrupt on each rising edge of a line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_reg <= 2'h0;
            irq_cnt <= 8'h00;
            fiq_cnt <= 8'h00;
        end else begin
            last_reg <= {fast_interrupt_line, normal_interrupt_line};
            irq_cnt <= irq_cnt + {7'h00, normal_interrupt_line & ~last_reg[0]};
            fiq_cnt <= fiq_cnt + {7'h00, fast_interrupt_line & ~last_reg[1]};
        end
    end
endmodule : crsig_core_model

/* File: crsig_ctrl_checker.sv */
`timescale 1ns/1ns
module crsig_checker (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // write bus
    input wire logic [crsig_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [crsig_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    // read bus
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // pending and lines
    input wire logic g0_pending,
    input wire logic g1_pending,
    input wire logic normal_interrupt_line,
    input wire logic fast_interrupt_line
);
    import crsig_pkg::*;
    // shadow tracks only writes whose halves arrive together
    logic [6:0] ctl_reg;
    logic [6:0] ctl_next;
    always_comb begin
        ctl_next = ctl_reg;
        if (awvalid && awready && wvalid && wready && awaddr == CTRL_OFS && wstrb[0]) begin
            ctl_next = wdata[6:0] & CTRL_WMASK[6:0];
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_reg <= 7'h00;
        end else begin
            ctl_reg <= ctl_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !ce);
    sequence s_wr_both;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    a_write_answer: assert property (s_wr_both |=> bvalid)
        else $error("write response not one cycle after request");
    a_read_answer: assert property (s_rd_take |=> rvalid)
        else $error("read data not one cycle after request");
    a_read_busy: assert property (rvalid |-> !arready)
        else $error("read address accepted during read data");
    a_write_busy: assert property (bvalid |-> !(awready || wready))
        else $error("write accepted during write response");
    a_g0_normal: assert property (ctl_reg[0] && !ctl_reg[3] && g0_pending |=> normal_interrupt_line)
        else $error("group 0 missing on normal line");
    a_g0_fast: assert property (ctl_reg[0] && ctl_reg[3] && g0_pending |=> fast_interrupt_line)
        else $error("group 0 missing on fast line");
    a_g1_normal_only: assert property (ctl_reg[1] && g1_pending && !ctl_reg[0] && ctl_reg[5]
        |=> normal_interrupt_line && !fast_interrupt_line)
        else $error("group 1 not on normal line alone");
    a_irq_bypass_off: assert property (ctl_reg[6] && !ctl_reg[1] && !(ctl_reg[0] && !ctl_reg[3])
        |=> !normal_interrupt_line)
        else $error("normal bypass not blocked");
    a_fiq_bypass_off: assert property (ctl_reg[5] && !(ctl_reg[0] && ctl_reg[3]) |=> !fast_interrupt_line)
        else $error("fast bypass not blocked");
endmodule : crsig_checker
bind crsig_ctrl crsig_checker u_crsig_checker (.clk, .nrst, .ce, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid,
    .g0_pending, .g1_pending, .normal_interrupt_line, .fast_interrupt_line);

/* File: crsig_ctrl_test.sv */
`timescale 1ns/1ns
module crsig_ctrl_test;
    import crsig_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sys_intr, g0_preempt, g1_preempt;
    logic [1:0] bresp, rresp, r;
    logic g0_pending = 1'b0, g1_pending = 1'b0, bypass_irq_pin = 1'b0, bypass_fiq_pin = 1'b0;
    logic [PRIO_W-1:0] g0_cand_prio = '0, g1_cand_prio = '0, running_prio = '0;
    logic normal_interrupt_line, fast_interrupt_line;
    logic [7:0] irq_cnt, fiq_cnt;
    int errors = 0, tests_run = 0, cycles = 0;
    // routing cases: control value, {g0, g1, bypass irq, bypass fiq}, {normal, fast}
    logic [7:0] cv [9] = '{8'h01, 8'h09, 8'h2A, 8'h08, 8'h00, 8'h60, 8'h20, 8'h40, 8'h0B};
    logic [3:0] iv [9] = '{4'h8, 4'h8, 4'h4, 4'h8, 4'h3, 4'h3, 4'h3, 4'h3, 4'hC};
    logic [1:0] ev [9] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h3, 2'h0, 2'h2, 2'h1, 2'h3};

    crsig_ctrl u_crsig_ctrl (.clk, .nrst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .g0_pending, .g1_pending, .g0_cand_prio, .g1_cand_prio, .running_prio,
        .bypass_irq_pin, .bypass_fiq_pin, .normal_interrupt_line, .fast_interrupt_line,
        .g0_preempt, .g1_preempt, .sys_intr);
    crsig_core_model u_crsig_core_model (.clk, .nrst, .normal_interrupt_line,
        .fast_interrupt_line, .irq_cnt, .fiq_cnt);

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic close_out;
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // a run of a few thousand cycles means a handshake never came
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            $display("unexpected at %0t: timeout", $time);
            close_out;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // readies and valids move only at rising edges, so the falling edge shows the edge's value
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic ad, wd, ar, wr_ok, bv;
        ad = 1'b0;
        wd = 1'b0;
        bv = 1'b0;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge clk);
            ar = awready;
            wr_ok = wready;
            @(posedge clk);
            if (!ad && ar) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wr_ok) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bv) begin
            @(negedge clk);
            bv = bvalid;
            r = bresp;
            @(posedge clk);
        end
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ar, rv;
        ar = 1'b0;
        rv = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!ar) begin
            @(negedge clk);
            ar = arready;
            @(posedge clk);
        end
        arvalid <= 1'b0;
        while (!rv) begin
            @(negedge clk);
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic probe(input logic [4:0] m, input logic [4:0] e, input string s);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({27'h0, m & {sys_intr, normal_interrupt_line, fast_interrupt_line, g0_preempt,
            g1_preempt}}, {27'h0, e}, s);
        @(posedge clk);
    endtask : probe

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(CTRL_OFS);
        chk(d, 32'h0, "control reset");
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "mapped read");
        rd(BPR_OFS);
        chk(d, 32'h0, "main binary point reset");
        rd(ABPR_OFS);
        chk(d, 32'h0, "aliased binary point reset");
        rd(8'h20);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
        wr(8'h20, 32'hFFFFFFFF, 4'hF);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
        wr(CTRL_OFS, 32'hFFFFFFFF, 4'h0);
        rd(CTRL_OFS);
        chk(d, 32'h0, "write without lane 0");
        wr(CTRL_OFS, 32'hFFFFFFFF, 4'hF);
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "mapped write");
        rd(CTRL_OFS);
        chk(d, CTRL_WMASK, "control fields");
        for (int i = 0; i < 9; i++) begin
            {g0_pending, g1_pending, bypass_irq_pin, bypass_fiq_pin} <= iv[i];
            wr(CTRL_OFS, {24'h0, cv[i]}, 4'hF);
            probe(5'h0C, {1'b0, ev[i], 2'h0}, "line routing");
        end
        chk({31'h0, fiq_cnt == 8'h00}, 32'h0, "core took fast line");
        chk({31'h0, irq_cnt == 8'h00}, 32'h0, "core took normal line");
        g0_cand_prio <= 8'h10;
        g1_cand_prio <= 8'h10;
        running_prio <= 8'h12;
        wr(BPR_OFS, 32'h3, 4'hF);
        wr(ABPR_OFS, 32'h0, 4'hF);
        wr(CTRL_OFS, 32'h03, 4'hF);
        probe(5'h03, 5'h01, "separate binary points");
        wr(CTRL_OFS, 32'h13, 4'hF);
        probe(5'h03, 5'h00, "common binary point");
        wr(BPR_OFS, 32'h0, 4'hF);
        probe(5'h03, 5'h03, "common main point");
        {g0_pending, g1_pending} <= 2'h0;
        wr(CTRL_OFS, 32'h0, 4'hF);
        repeat (4) @(posedge clk);
        rd(STAT_OFS);
        chk(d, 32'h7, "all events latched");
        wr(STAT_OFS, 32'h7, 4'hF);
        rd(STAT_OFS);
        chk(d, 32'h0, "status cleared");
        wr(MASK_OFS, 32'h1, 4'hF);
        g0_pending <= 1'b1;
        wr(CTRL_OFS, 32'h01, 4'hF);
        probe(5'h18, 5'h18, "interrupt raised");
        rd(STAT_OFS);
        chk(d, 32'h1, "status set");
        rd(LINE_OFS);
        chk(d, 32'h1, "line state");
        wr(LINE_OFS, 32'hF, 4'hF);
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "line state write ignored");
        wr(MASK_OFS, 32'h0, 4'hF);
        probe(5'h10, 5'h00, "interrupt masked");
        wr(STAT_OFS, 32'h1, 4'hF);
        rd(STAT_OFS);
        chk(d, 32'h0, "status write one clear");
        // with the enable low the line must hold although the pending input drops
        ce <= 1'b0;
        g0_pending <= 1'b0;
        probe(5'h08, 5'h08, "clock enable freeze");
        ce <= 1'b1;
        probe(5'h08, 5'h00, "clock enable run");
        close_out;
    end
endmodule : crsig_ctrl_test
